// ---- common/socket_regs_map.vh ----
// register offsets, field positions and reset values of the socket bank
`ifndef SOCKET_REGS_MAP_VH
`define SOCKET_REGS_MAP_VH
`define ADDR_W 5
`define OFS_EVENT 5'h00
`define OFS_IRQ_ENABLE 5'h04
`define OFS_CONDITION 5'h08
`define OFS_FORCE 5'h0c
// interrupt enable fields
`define EN_PWR_BIT 3
`define EN_CD_HI 2
`define EN_CD_LO 1
`define EN_CSTS_BIT 0
`define EN_RESET 4'h0
`define CD_ENABLE_CODE 2'b11
// event flag positions
`define EV_PWR 3
`define EV_CD2 2
`define EV_CD1 1
`define EV_CSTS 0
// current condition fields
`define CC_YY_SOCK 31
`define CC_XX_SOCK 30
`define CC_3V3_SOCK 29
`define CC_5V_SOCK 28
`define CC_VOLT_HI 13
`define CC_VOLT_LO 10
`define CC_FAULT_HI 9
`define CC_FAULT_LO 7
`define CC_READY 6
`define CC_CARDBUS 5
`define CC_16BIT 4
`define CC_POWERED 3
`define CC_CD2 2
`define CC_CD1 1
`define CC_CSTS 0
`define SOCK_CAP_RESET 4'h3
// synchroniser and mirror reset levels: detect pins high, socket empty
`define PIN_SYNC_RESET 6'h03
`define CD_EMPTY_LEVEL 1'b1
`define LEVEL_RESET 4'h6
// force event fields
`define FE_SOCK_HI 31
`define FE_SOCK_LO 28
`define FE_CVSTEST 14
`define FE_VOLT_HI 13
`define FE_VOLT_LO 10
`define FE_FAULT_HI 9
`define FE_FAULT_LO 7
`define FE_EVENT_HI 3
`define FE_EVENT_LO 0
`endif

// ---- hw/socket_event_flags.v ----
// sticky socket event flags and the masked status-change request
`timescale 1ns/1ps
`include "socket_regs_map.vh"
module socket_event_flags (
  input wire clock_i,
  input wire reset_i,
  input wire ctx_clear_i,
  input wire cardbus_mode_i,
  input wire [3:0] level_i,
  input wire [3:0] w1c_i,
  input wire [3:0] force_i,
  input wire [3:0] enable_i,
  output reg [3:0] flags_o,
  output wire irq_req_o
);
  reg [3:0] level_prev_reg;
  reg [3:0] flags_next;
  wire [3:0] change;
  wire csts_rise;
  wire csts_edge;
  wire cd_enabled;

  // previous levels for edge detection; reset matches an empty socket,
  // so leaving reset does not fake a card-detect edge
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      level_prev_reg <= `LEVEL_RESET;
    end else begin
      level_prev_reg <= level_i;
    end
  end

  assign change = level_i ^ level_prev_reg;
  assign csts_rise = level_i[`EV_CSTS] & ~level_prev_reg[`EV_CSTS];
  // cardbus cards flag rising edges only, 16-bit cards both edges
  assign csts_edge = cardbus_mode_i ? csts_rise : change[`EV_CSTS];

  // flags react whatever the enables say; set beats a same-cycle clear
  always @* begin
    flags_next = flags_o & ~w1c_i;
    flags_next[`EV_PWR] = flags_next[`EV_PWR] | change[`EV_PWR];
    flags_next[`EV_CD2] = flags_next[`EV_CD2] | change[`EV_CD2];
    flags_next[`EV_CD1] = flags_next[`EV_CD1] | change[`EV_CD1];
    flags_next[`EV_CSTS] = flags_next[`EV_CSTS] | csts_edge;
    flags_next = flags_next | force_i;
  end

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      flags_o <= 4'h0;
    end else if (ctx_clear_i) begin
      flags_o <= 4'h0;
    end else begin
      flags_o <= flags_next;
    end
  end

  // reserved card-detect codes count as disabled
  assign cd_enabled = (enable_i[`EN_CD_HI:`EN_CD_LO] == `CD_ENABLE_CODE);
  // stale flags raise the request as soon as they are enabled
  assign irq_req_o = (flags_o[`EV_PWR] & enable_i[`EN_PWR_BIT]) |
    ((flags_o[`EV_CD2] | flags_o[`EV_CD1]) & cd_enabled) |
    (flags_o[`EV_CSTS] & enable_i[`EN_CSTS_BIT]);
endmodule

// ---- hw/cardbus_socket_mask_and_state.v ----
// socket interrupt enable and current condition registers of the socket
// Notes on behaviour
// - event flags keep setting on changes; enables only gate the interrupt.
// - enable bits 31-4 and condition bits 27-14 read as zero.
// - enable bit 3 lets power-cycle events interrupt; default blocks.
// - card-detect enable field bits 2-1: 00 blocks, 11 enables.
// - enable bit 0 lets card status events interrupt; default blocks.
// - context bits clear on global reset, or bus reset if pme disabled.
// - force-event writes show up in the current condition register.
// - card voltage and type bits take identification results only when a card is inserted.
// - card-detect changes during identification are hidden.
// - condition resets to 3000_00xx; bits 6, 2-0 follow pins.
// - yy and xx volt socket bits read 0 unless forced.
// - 5 volt socket bit reads 1 unless forced or device control bit 6 overrides.
// - card voltage bits 13-10 read-only, set by force-event ones.
// - interrupt whenever an enabled event flag is set, old ones too.
// - card status flag on rising edge for cardbus, both for 16-bit.
// - bit 0 status pin, bits 1-2 detect pins, bit 3 power state.
`timescale 1ns/1ps
`include "socket_regs_map.vh"
module cardbus_socket_mask_and_state (
  input wire clock_i,
  input wire reset_i,
  input wire bus_reset_i,
  input wire pme_enable_i,
  input wire [`ADDR_W-1:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_wdata_i,
  input wire card_detect_pin_one_i,
  input wire card_detect_pin_two_i,
  input wire card_status_change_pin_i,
  input wire ready_pin_i,
  input wire socket_powered_i,
  input wire socket_5v_disable_i,
  input wire ident_busy_i,
  input wire ident_done_i,
  input wire ident_cardbus_i,
  input wire ident_16bit_i,
  input wire ident_notacard_i,
  input wire [3:0] ident_volt_i,
  output reg [31:0] reg_rdata_o,
  output reg status_change_interrupt_o,
  output reg reinterrogate_o,
  output reg [3:0] event_flags_o
);
  // two-stage synchronisers for the card pins and the bus reset
  reg [5:0] pin_meta_reg;
  reg [5:0] pin_sync_reg;
  wire [5:0] pin_async;
  wire cd1_s;
  wire cd2_s;
  wire csts_s;
  wire ready_s;
  wire bus_reset_s;
  wire ctx_clear;

  // condition register state
  reg [3:0] sock_cap_reg;
  reg [3:0] card_volt_reg;
  reg [2:0] fault_reg;
  reg cardbus_reg;
  reg bit16_reg;
  reg powered_reg;
  reg cd1_reg;
  reg cd2_reg;
  reg csts_reg;
  reg ready_reg;
  reg [3:0] irq_enable_reg;

  // decoded accesses
  wire wr_event;
  wire wr_enable;
  wire wr_force;
  wire card_present;
  wire [3:0] flags;
  wire irq_req;
  wire [3:0] w1c;
  wire [3:0] force_ev;
  wire [3:0] levels;
  wire [31:0] condition;
  wire [31:0] enable_word;
  reg [31:0] rdata_next;

  assign pin_async = {bus_reset_i, socket_powered_i, ready_pin_i,
    card_status_change_pin_i, card_detect_pin_two_i,
    card_detect_pin_one_i};

  // the first stage is read only by the second stage
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pin_meta_reg <= `PIN_SYNC_RESET;
      pin_sync_reg <= `PIN_SYNC_RESET;
    end else begin
      pin_meta_reg <= pin_async;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign cd1_s = pin_sync_reg[0];
  assign cd2_s = pin_sync_reg[1];
  assign csts_s = pin_sync_reg[2];
  assign ready_s = pin_sync_reg[3];
  assign bus_reset_s = pin_sync_reg[5];

  // bus reset clears context bits only while pme is off
  assign ctx_clear = bus_reset_s & ~pme_enable_i;

  assign wr_event = reg_wr_i & (reg_addr_i == `OFS_EVENT);
  assign wr_enable = reg_wr_i & (reg_addr_i == `OFS_IRQ_ENABLE);
  assign wr_force = reg_wr_i & (reg_addr_i == `OFS_FORCE);

  // detect pins are active low, so both low means a card sits there
  assign card_present = ~cd1_reg & ~cd2_reg;

  // interrupt enable register, context bits
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      irq_enable_reg <= `EN_RESET;
    end else if (ctx_clear) begin
      irq_enable_reg <= `EN_RESET;
    end else if (wr_enable) begin
      irq_enable_reg <= reg_wdata_i[3:0];
    end
  end

  // live levels; the detect mirrors freeze while identification drives
  // those pins, so the bus never sees our own probing
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      csts_reg <= 1'b0;
      ready_reg <= 1'b0;
      cd1_reg <= `CD_EMPTY_LEVEL; // idle pin level, no false event
      cd2_reg <= `CD_EMPTY_LEVEL;
      powered_reg <= 1'b0;
    end else begin
      csts_reg <= csts_s;
      ready_reg <= ready_s;
      if (ctx_clear) begin
        cd1_reg <= 1'b0;
        cd2_reg <= 1'b0;
        powered_reg <= 1'b0;
      end else begin
        powered_reg <= pin_sync_reg[4];
        if (!ident_busy_i) begin
          cd1_reg <= cd1_s;
          cd2_reg <= cd2_s;
        end
      end
    end
  end

  // socket capability: yy/xx off, 3.3 on, unless forced by software
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      sock_cap_reg <= `SOCK_CAP_RESET;
    end else if (wr_force) begin
      sock_cap_reg <= reg_wdata_i[`FE_SOCK_HI:`FE_SOCK_LO];
    end
  end

  // card voltage and type bits move only on identification of an
  // inserted card; force writes can still set voltage bits
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      card_volt_reg <= 4'h0;
      cardbus_reg <= 1'b0;
      bit16_reg <= 1'b0;
      fault_reg <= 3'h0;
    end else if (ctx_clear) begin
      card_volt_reg <= 4'h0;
      cardbus_reg <= 1'b0;
      bit16_reg <= 1'b0;
      fault_reg <= 3'h0;
    end else begin
      if (ident_done_i && card_present) begin
        card_volt_reg <= ident_volt_i;
        cardbus_reg <= ident_cardbus_i;
        bit16_reg <= ident_16bit_i;
        fault_reg[0] <= ident_notacard_i;
      end else if (wr_force) begin
        card_volt_reg <= card_volt_reg |
          reg_wdata_i[`FE_VOLT_HI:`FE_VOLT_LO];
        fault_reg <= fault_reg |
          reg_wdata_i[`FE_FAULT_HI:`FE_FAULT_LO];
      end
    end
  end

  // a cvstest write asks the socket logic to probe the card again
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      reinterrogate_o <= 1'b0;
    end else begin
      reinterrogate_o <= wr_force & reg_wdata_i[`FE_CVSTEST];
    end
  end

  assign w1c = wr_event ? reg_wdata_i[3:0] : 4'h0;
  assign force_ev = wr_force ?
    reg_wdata_i[`FE_EVENT_HI:`FE_EVENT_LO] : 4'h0;
  assign levels = {powered_reg, cd2_reg, cd1_reg, csts_reg};

  socket_event_flags u_flags (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .ctx_clear_i(ctx_clear),
    .cardbus_mode_i(cardbus_reg),
    .level_i(levels),
    .w1c_i(w1c),
    .force_i(force_ev),
    .enable_i(irq_enable_reg),
    .flags_o(flags),
    .irq_req_o(irq_req)
  );

  // registered interrupt and flag copies for the outside
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      status_change_interrupt_o <= 1'b0;
      event_flags_o <= 4'h0;
    end else begin
      status_change_interrupt_o <= irq_req;
      event_flags_o <= flags;
    end
  end

  // 5 v socket capability is pulled by the device control strap bit
  assign condition = {sock_cap_reg[3:1],
    sock_cap_reg[0] & ~socket_5v_disable_i,
    14'h0000,
    card_volt_reg, fault_reg, ready_reg, cardbus_reg, bit16_reg,
    powered_reg, cd2_reg, cd1_reg, csts_reg};
  assign enable_word = {28'h0000000, irq_enable_reg};

  // read mux; unmapped offsets and the write-only force register read 0
  always @* begin
    case (reg_addr_i)
      `OFS_EVENT: begin
        rdata_next = {28'h0000000, flags};
      end
      `OFS_IRQ_ENABLE: begin
        rdata_next = enable_word;
      end
      `OFS_CONDITION: begin
        rdata_next = condition;
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  // read data is captured on the strobe and held until the next read
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_next;
    end
  end
endmodule

// ---- dv/cardbus_socket_mask_and_state_asserts.sv ----
// assertion checker for the socket enable and condition registers
`timescale 1ns/1ps
module cardbus_socket_mask_and_state_asserts (
  input wire clock_i,
  input wire reset_i,
  input wire bus_reset_i,
  input wire socket_5v_disable_i,
  input wire [4:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_wdata_i,
  input wire [31:0] reg_rdata_o,
  input wire status_change_interrupt_o,
  input wire [3:0] event_flags_o
);
  // bus reset lands late through its synchroniser, so stay quiet meanwhile
  reg [2:0] br_q = 3'h0;
  always @(posedge clock_i) begin
    br_q <= {br_q[1:0], bus_reset_i};
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i || bus_reset_i || |br_q);
  // decoded register strobes
  wire wr_en = reg_wr_i && reg_addr_i == 5'h04;
  wire rd_en = reg_rd_i && reg_addr_i == 5'h04;
  wire rd_cc = reg_rd_i && reg_addr_i == 5'h08;
  chk_en_resv: assert property (
    rd_en |=> reg_rdata_o[31:4] == 28'h0) else $error("enable high bits set");
  chk_cc_resv: assert property (
    rd_cc |=> reg_rdata_o[27:14] == 14'h0) else $error("condition gap set");
  chk_5v_off: assert property (
    rd_cc && socket_5v_disable_i && $past(socket_5v_disable_i)
    |=> !reg_rdata_o[28]) else $error("5v socket bit not cleared");
  chk_en_back: assert property (
    wr_en ##1 rd_en |=> reg_rdata_o[3:0] == $past(reg_wdata_i[3:0], 2))
    else $error("enable readback wrong");
  chk_irq_raise: assert property (
    wr_en && reg_wdata_i[3:0] == 4'hf ##1 event_flags_o != 4'h0
    |=> status_change_interrupt_o) else $error("interrupt missing");
  chk_mask_off: assert property (
    wr_en && reg_wdata_i[3:0] == 4'h0 |-> ##2 !status_change_interrupt_o)
    else $error("interrupt while all disabled");
  chk_cd_resv: assert property (
    wr_en && (reg_wdata_i[3:0] == 4'h2 || reg_wdata_i[3:0] == 4'h4)
    |=> ##1 !status_change_interrupt_o) else $error("reserved code fired");
  // flag copies lag a write by two edges, so look one write further back
  chk_flags_hold: assert property (
    !$past(reg_wr_i) |=> (event_flags_o & $past(event_flags_o))
    == $past(event_flags_o)) else $error("event flag dropped");
endmodule
bind cardbus_socket_mask_and_state cardbus_socket_mask_and_state_asserts
  chk_u (.clock_i, .reset_i, .bus_reset_i, .socket_5v_disable_i,
  .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
  .status_change_interrupt_o, .event_flags_o);

// ---- dv/socket_card_model.sv ----
// behavioural card in the socket: detect, status, ready and sense lines
`timescale 1ns/1ps
module socket_card_model (
  input wire present_i,
  input wire status_i,
  input wire [3:0] volt_i,
  output wire card_detect_pin_one_o,
  output wire card_detect_pin_two_o,
  output wire card_status_change_pin_o,
  output wire ready_pin_o,
  output wire [3:0] ident_volt_o
);
  // empty socket: pulled-up detect lines, status line pulled down
  assign card_detect_pin_one_o = !present_i;
  assign card_detect_pin_two_o = !present_i;
  assign card_status_change_pin_o = present_i & status_i;
  assign ready_pin_o = present_i;
  // sense lines float high without a card, so stale results look valid
  assign ident_volt_o = present_i ? volt_i : 4'hf;
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the socket enable and condition registers
`timescale 1ns/1ps
module tb;
  reg clock_i, reset_i, bus_reset_i, pme_enable_i, reg_wr_i, reg_rd_i;
  reg socket_powered_i, socket_5v_disable_i, ident_busy_i, ident_done_i;
  reg ident_cardbus_i, present, sts;
  reg [4:0] reg_addr_i;
  reg [31:0] reg_wdata_i, rdv;
  reg [3:0] volt;
  wire [31:0] reg_rdata_o;
  wire [3:0] event_flags_o, card_volt;
  wire status_change_interrupt_o, cd1, cd2, csts, rdy, reint;
  integer seed, i, n, err_count, num_checks;
  // card model and the register bank
  socket_card_model card_u (.present_i(present), .status_i(sts),
    .volt_i(volt), .card_detect_pin_one_o(cd1), .card_detect_pin_two_o(cd2),
    .card_status_change_pin_o(csts), .ready_pin_o(rdy),
    .ident_volt_o(card_volt));
  cardbus_socket_mask_and_state dut_u (.clock_i, .reset_i, .bus_reset_i,
    .pme_enable_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .card_detect_pin_one_i(cd1), .card_detect_pin_two_i(cd2),
    .card_status_change_pin_i(csts), .ready_pin_i(rdy), .socket_powered_i,
    .socket_5v_disable_i, .ident_busy_i, .ident_done_i, .ident_cardbus_i,
    .ident_16bit_i(!ident_cardbus_i), .ident_notacard_i(1'b0),
    .ident_volt_i(card_volt), .reg_rdata_o, .status_change_interrupt_o,
    .reinterrogate_o(reint), .event_flags_o);
  // 50 ns clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobes stay up between back-to-back accesses of one kind, dropped by idle or by the other kind of access
  task wr(input [4:0] a, input [31:0] d);
    reg_rd_i = 1'b0;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clock_i);
  endtask
  task rd(input [4:0] a);
    reg_wr_i = 1'b0;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clock_i);
    rdv = reg_rdata_o;
  endtask
  task idle(input integer c);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (c) @(negedge clock_i);
  endtask
  // bounded wait for event flags; running out ends the run
  task wait_flag(input [3:0] m);
    for (n = 0; n < 12 && (event_flags_o & m) !== m; n = n + 1)
      @(negedge clock_i);
    chk(event_flags_o & m, m);
    if ((event_flags_o & m) !== m) end_of_test;
  endtask
  // one identification result pulse
  task ident;
    ident_done_i = 1'b1;
    idle(1);
    ident_done_i = 1'b0;
  endtask
  function [31:0] live();
    live = {25'h0, rdy, 2'b0, socket_powered_i, cd2, cd1, csts};
  endfunction
  // main sequence
  initial begin
    seed = 71;
    err_count = 0;
    num_checks = 0;
    {reset_i, bus_reset_i, pme_enable_i, reg_wr_i, reg_rd_i} = 5'h10;
    {socket_powered_i, socket_5v_disable_i, ident_busy_i} = 3'h0;
    {ident_done_i, ident_cardbus_i, present, sts} = 4'h0;
    reg_addr_i = 5'h00;
    reg_wdata_i = 32'h0;
    volt = 4'h0;
    repeat (3) @(negedge clock_i);
    reset_i = 1'b0;
    idle(5);
    rd(5'h04);
    chk(rdv, 32'h0);
    rd(5'h08);
    chk(rdv, 32'h3000_0000 | live());
    for (i = 0; i < 16; i = i + 1) begin
      wr(5'h04, {$random(seed)} & 32'hffff_fff0 | i);
      rd(5'h04);
      chk(rdv, i);
    end
    rd(5'h14);
    chk(rdv, 32'h0);
    wr(5'h04, 32'h0);
    wr(5'h00, 32'hf);
    present = 1'b1;
    idle(1);
    wait_flag(4'h6);
    chk(status_change_interrupt_o, 1'b0);
    wr(5'h04, 32'h2);
    idle(3);
    chk(status_change_interrupt_o, 1'b0);
    wr(5'h04, 32'h6);
    idle(3);
    chk(status_change_interrupt_o, 1'b1);
    // 16-bit card: both status edges count
    wr(5'h04, 32'h0);
    wr(5'h00, 32'hf);
    sts = 1'b1;
    idle(1);
    wait_flag(4'h1);
    wr(5'h00, 32'h1);
    sts = 1'b0;
    idle(1);
    wait_flag(4'h1);
    wr(5'h04, 32'h1);
    idle(3);
    chk(status_change_interrupt_o, 1'b1);
    wr(5'h00, 32'hf);
    socket_powered_i = 1'b1;
    idle(1);
    wait_flag(4'h8);
    wr(5'h04, 32'h8);
    idle(3);
    chk(status_change_interrupt_o, 1'b1);
    // removal hidden while identification runs
    ident_busy_i = 1'b1;
    present = 1'b0;
    idle(8);
    rd(5'h08);
    chk(rdv[2:1], 2'b00);
    ident_busy_i = 1'b0;
    idle(8);
    rd(5'h08);
    chk(rdv[2:1], 2'b11);
    ident;
    rd(5'h08);
    chk(rdv[13:10], 4'h0);
    present = 1'b1;
    ident_cardbus_i = 1'b1;
    volt = $random(seed);
    idle(8);
    ident;
    rd(5'h08);
    chk(rdv[13:4], {volt, 6'h06});
    // cardbus card: falling status edge is ignored
    wr(5'h00, 32'hf);
    sts = 1'b1;
    idle(1);
    wait_flag(4'h1);
    wr(5'h00, 32'h1);
    sts = 1'b0;
    idle(8);
    chk(event_flags_o[0], 1'b0);
    wr(5'h0c, 32'hc000_3f80);
    chk(reint, 1'b0);
    rd(5'h08);
    chk(rdv[31:28], 4'hc);
    chk(rdv[13:10], 4'hf);
    chk(rdv[9:7], 3'h7);
    // force write with the probe bit and a forced status event
    wr(5'h0c, 32'h3000_4001);
    chk(reint, 1'b1);
    socket_5v_disable_i = 1'b1;
    idle(2);
    chk(reint, 1'b0);
    chk(event_flags_o[0], 1'b1);
    rd(5'h08);
    chk(rdv[31:28], 4'h2);
    // bus reset spares context bits only while pme is enabled
    wr(5'h04, 32'hf);
    for (i = 1; i >= 0; i = i - 1) begin
      pme_enable_i = i;
      bus_reset_i = 1'b1;
      idle(4);
      bus_reset_i = 1'b0;
      idle(4);
      rd(5'h04);
      chk(rdv, i ? 32'hf : 32'h0);
    end
    // global reset in mid-run clears context bits even with pme on
    pme_enable_i = 1'b1;
    wr(5'h04, 32'hf);
    reset_i = 1'b1;
    idle(2);
    reset_i = 1'b0;
    idle(4);
    rd(5'h04);
    chk(rdv, 32'h0);
    rd(5'h08);
    chk(rdv[13:4], 10'h004);
    end_of_test;
  end
endmodule
